// [shared/lsr_pkg.sv]
// package: widths, offsets, types and reset values of the shift/rotate unit
`default_nettype none

package lsr_pkg;

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int HALF_W = 16;
	localparam int WORD_W = 32;
	localparam int ACC_W  = 40;
	localparam int AMT_W  = 32;
	localparam int MAG_W  = 6;
	localparam int IDX_W  = 4;
	localparam int BUS_AW = 8;
	localparam int BUS_DW = 32;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [BUS_AW-1:0] ADDR_STATUS = 8'h00;
	localparam logic [BUS_AW-1:0] ADDR_RES_LO = 8'h04;
	localparam logic [BUS_AW-1:0] ADDR_RES_HI = 8'h08;

	// ---------------------------------------------------------------
	// amounts and reset values
	// ---------------------------------------------------------------
	localparam logic [AMT_W-1:0] ASG_MAX_AMT = 32'h0000001f;
	localparam logic [MAG_W-1:0] PTR_STEP1   = 6'h01;
	localparam logic [MAG_W-1:0] PTR_STEP2   = 6'h02;
	localparam logic [5:0]       FLAGS_RST   = 6'h00;
	localparam logic [ACC_W-1:0] RES_RST     = 40'h0000000000;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_PTR_R1,
		OP_PTR_R2,
		OP_PTR_L1,
		OP_PTR_L2,
		OP_ASG_RIGHT,
		OP_ASG_LEFT,
		OP_IMM_RIGHT,
		OP_IMM_LEFT,
		OP_LSHIFT,
		OP_ROT
	} lsr_op_t;

	typedef enum logic [2:0] {
		DK_HALF,
		DK_WORD,
		DK_ACC0,
		DK_ACC1,
		DK_PTR
	} lsr_kind_t;

	typedef struct packed {
		lsr_op_t          op;
		lsr_kind_t        kind;
		logic [ACC_W-1:0] operand;
		logic [AMT_W-1:0] amount;
		logic [IDX_W-1:0] dest_idx;
		logic             parallel;
	} lsr_req_t;

	typedef struct packed {
		lsr_kind_t        kind;
		logic [IDX_W-1:0] dest_idx;
		logic [ACC_W-1:0] data;
	} lsr_res_t;

	// bit 0 is the carry chain bit, bit 5 the second accumulator overflow
	typedef struct packed {
		logic acc1_oflow_flag;
		logic acc0_oflow_flag;
		logic data_oflow_flag;
		logic result_negative_flag;
		logic result_zero_flag;
		logic carry_chain_bit;
	} lsr_flags_t;

endpackage

`default_nettype wire

// [hdl/lsr_barrel.sv]
// module: one-width logical shifter and rotator through the carry bit
`timescale 1ns/100ps
`default_nettype none

module lsr_barrel #(
	parameter int W = 32
) (
	input  wire logic [W-1:0]       data_in,
	input  wire logic               carry_in,
	input  wire logic [5:0]         mag_in,
	input  wire logic               clear_in,
	output logic      [W-1:0]       shl_out,
	output logic      [W-1:0]       shr_out,
	output logic      [W-1:0]       rol_out,
	output logic      [W-1:0]       ror_out,
	output logic                    rol_carry_out,
	output logic                    ror_carry_out
);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	localparam int RW = W + 1;

	// rotates wrap wrongly once the magnitude can exceed the ring length
	if (W < 32) begin : g_narrow
		if (W < 2) begin : g_bad
			$error("lsr_barrel: width below 2");
		end
	end

	// ---------------------------------------------------------------
	// datapath
	// ---------------------------------------------------------------
	logic [RW-1:0]   ring;
	logic [2*RW-1:0] dbl;
	logic [2*RW-1:0] rl_w;
	logic [2*RW-1:0] rr_w;
	logic            over;

	assign ring = {carry_in, data_in};
	assign dbl  = {ring, ring};
	assign over = clear_in || (int'(mag_in) >= W);   // RULE11

	// whole barrel in one pass: any amount costs the same time
	assign shl_out = over ? '0 : (data_in << mag_in);   // RULE1
	assign shr_out = over ? '0 : (data_in >> mag_in);   // RULE1

	assign rl_w = dbl << mag_in;   // RULE17
	assign rr_w = dbl >> mag_in;   // RULE17

	assign rol_out       = rl_w[2*RW-2:RW];   // RULE18
	assign rol_carry_out = rl_w[2*RW-1];      // RULE18
	assign ror_out       = rr_w[RW-2:0];      // RULE18
	assign ror_carry_out = rr_w[RW-1];        // RULE18

endmodule

`default_nettype wire

// [hdl/lsr_shift_rotate_unit.sv]
// module: logical shift and rotate unit with status flags and register port
//
// Operation
// RULE1 - logical shifts drop bits shifted out and fill vacated bits with zero
// RULE2 - four pointer shifts, flags untouched, source changes only if dest
// RULE3 - pointer shifts: right 1, right 2, left 1, left 2; 32-bit result
// RULE4 - short in-place shifts act on the destination word, always 32 bits
// RULE5 - short forms use full 32-bit amount; above 0x1f gives zero
// RULE6 - bidirectional shift amount is low 6 bits of amount, sign-extended
// RULE7 - bidirectional shift: positive goes left, negative goes right
// RULE8 - bidirectional shift accepts -32 to +31 on words and accumulators
// RULE9 - constant shifts: 4-bit amount on half-words, 5-bit on wider ones
// RULE10 - half-words shift 16 bits, words 32, accumulators all 40
// RULE11 - amount not below destination width yields an all-zero result
// RULE12 - zero amount passes the operand through with normal flag update
// RULE13 - source stays unchanged unless it is also the destination
// RULE14 - data shifts set zero and negative, clear data overflow only
// RULE15 - accumulator shifts set zero and negative, clear its overflow
// RULE16 - short forms never issue in parallel; long forms may
// RULE17 - rotate chain holds the carry bit; its old value enters first
// RULE18 - bit leaving goes to carry, old carry fills the opposite end
// RULE19 - rotate amount is signed 6-bit immediate or low half of a register
// RULE20 - rotate: positive left, negative right, sign-extended low 6 bits
// RULE21 - data rotates act on 32 bits, accumulator rotates on 40
// RULE22 - rotate leaves last bit out in carry and changes no other flag
// RULE23 - every shift or rotate completes in one cycle whatever the amount
`timescale 1ns/100ps
`default_nettype none

module lsr_shift_rotate_unit (
	input  wire logic                       SYS_CLK_IN,
	input  wire logic                       RST_N_IN,
	input  wire lsr_pkg::lsr_req_t          REQ_IN,
	input  wire logic                       REQ_VALID_IN,
	output lsr_pkg::lsr_res_t               RES_OUT,
	output logic                            RES_VALID_OUT,
	output logic                            ISSUE_REFUSED_OUT,
	output lsr_pkg::lsr_flags_t             FLAGS_OUT,
	input  wire logic [lsr_pkg::BUS_AW-1:0] BUS_ADDR_IN,
	input  wire logic [lsr_pkg::BUS_DW-1:0] BUS_WDATA_IN,
	input  wire logic                       BUS_WR_IN,
	input  wire logic                       BUS_RD_IN,
	output logic      [lsr_pkg::BUS_DW-1:0] BUS_RDATA_OUT
);

	import lsr_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	lsr_flags_t        flags_reg;
	lsr_flags_t        flags_next;
	lsr_res_t          res_reg;
	lsr_res_t          res_next;
	logic              res_valid_reg;
	logic              refused_reg;
	logic [BUS_DW-1:0] rdata_reg;
	logic [BUS_DW-1:0] rdata_next;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	logic [MAG_W-1:0] mag;
	logic [MAG_W-1:0] sgn_amt;
	logic [MAG_W-1:0] neg_amt;
	logic             clear;
	logic             go_left;
	logic             is_rot;
	logic             is_short;
	logic             legal;
	logic             fire;
	logic             refuse;

	// low 6 bits, two's complement; -32 turns into a magnitude of 32
	assign sgn_amt = REQ_IN.amount[MAG_W-1:0];              // RULE6 RULE20
	assign neg_amt = MAG_W'(~sgn_amt + 6'h01);              // RULE7 RULE20

	always_comb begin
		mag      = '0;
		clear    = 1'b0;
		go_left  = 1'b0;
		is_rot   = 1'b0;
		is_short = 1'b0;
		legal    = 1'b0;
		case (REQ_IN.op)
			OP_PTR_R1: begin
				mag      = PTR_STEP1;                        // RULE3
				is_short = 1'b1;
				legal    = (REQ_IN.kind == DK_PTR);          // RULE2
			end
			OP_PTR_R2: begin
				mag      = PTR_STEP2;                        // RULE3
				is_short = 1'b1;
				legal    = (REQ_IN.kind == DK_PTR);          // RULE2
			end
			OP_PTR_L1: begin
				mag      = PTR_STEP1;                        // RULE3
				go_left  = 1'b1;
				is_short = 1'b1;
				legal    = (REQ_IN.kind == DK_PTR);          // RULE2
			end
			OP_PTR_L2: begin
				mag      = PTR_STEP2;                        // RULE3
				go_left  = 1'b1;
				is_short = 1'b1;
				legal    = (REQ_IN.kind == DK_PTR);          // RULE2
			end
			OP_ASG_RIGHT, OP_ASG_LEFT: begin
				mag      = REQ_IN.amount[MAG_W-1:0];
				clear    = (REQ_IN.amount > ASG_MAX_AMT);   // RULE5
				go_left  = (REQ_IN.op == OP_ASG_LEFT);
				is_short = 1'b1;
				legal    = (REQ_IN.kind == DK_WORD);         // RULE4
			end
			OP_IMM_RIGHT, OP_IMM_LEFT: begin
				if (REQ_IN.kind == DK_HALF) begin
					mag = {2'b00, REQ_IN.amount[3:0]};       // RULE9
				end else begin
					mag = {1'b0, REQ_IN.amount[4:0]};        // RULE9
				end
				go_left = (REQ_IN.op == OP_IMM_LEFT);
				legal   = (REQ_IN.kind != DK_PTR);
			end
			OP_LSHIFT: begin
				go_left = !sgn_amt[MAG_W-1];                 // RULE7
				mag     = go_left ? sgn_amt : neg_amt;       // RULE8
				legal   = (REQ_IN.kind != DK_PTR);
			end
			OP_ROT: begin
				go_left = !sgn_amt[MAG_W-1];                 // RULE20
				mag     = go_left ? sgn_amt : neg_amt;       // RULE19
				is_rot  = 1'b1;
				// half-word rotates do not exist
				legal   = (REQ_IN.kind != DK_PTR) &&
				          (REQ_IN.kind != DK_HALF);          // RULE21
			end
			default: begin
				legal = 1'b0;
			end
		endcase
	end

	// a short encoding flagged as paired is turned away whole
	assign refuse = REQ_VALID_IN && (!legal ||
	                (is_short && REQ_IN.parallel));         // RULE16
	assign fire   = REQ_VALID_IN && !refuse;

	// ---------------------------------------------------------------
	// shifters, one per width
	// ---------------------------------------------------------------
	logic [HALF_W-1:0] h_shl;
	logic [HALF_W-1:0] h_shr;
	logic [WORD_W-1:0] w_shl;
	logic [WORD_W-1:0] w_shr;
	logic [WORD_W-1:0] w_rol;
	logic [WORD_W-1:0] w_ror;
	logic              w_rol_c;
	logic              w_ror_c;
	logic [ACC_W-1:0]  a_shl;
	logic [ACC_W-1:0]  a_shr;
	logic [ACC_W-1:0]  a_rol;
	logic [ACC_W-1:0]  a_ror;
	logic              a_rol_c;
	logic              a_ror_c;

	// half-word rotate outputs unused; the unit only serves shifts there
	lsr_barrel #(.W(HALF_W)) u_half (
		.data_in       (REQ_IN.operand[HALF_W-1:0]),
		.carry_in      (flags_reg.carry_chain_bit),
		.mag_in        (mag),
		.clear_in      (clear),
		.shl_out       (h_shl),
		.shr_out       (h_shr),
		.rol_out       (),
		.ror_out       (),
		.rol_carry_out (),
		.ror_carry_out ()
	);

	lsr_barrel #(.W(WORD_W)) u_word (
		.data_in       (REQ_IN.operand[WORD_W-1:0]),
		.carry_in      (flags_reg.carry_chain_bit),
		.mag_in        (mag),
		.clear_in      (clear),
		.shl_out       (w_shl),
		.shr_out       (w_shr),
		.rol_out       (w_rol),
		.ror_out       (w_ror),
		.rol_carry_out (w_rol_c),
		.ror_carry_out (w_ror_c)
	);

	lsr_barrel #(.W(ACC_W)) u_acc (
		.data_in       (REQ_IN.operand),
		.carry_in      (flags_reg.carry_chain_bit),
		.mag_in        (mag),
		.clear_in      (clear),
		.shl_out       (a_shl),
		.shr_out       (a_shr),
		.rol_out       (a_rol),
		.ror_out       (a_ror),
		.rol_carry_out (a_rol_c),
		.ror_carry_out (a_ror_c)
	);

	// ---------------------------------------------------------------
	// result and flag selection
	// ---------------------------------------------------------------
	logic [ACC_W-1:0] sel_data;
	logic             sel_top;
	logic             sel_carry;

	always_comb begin
		sel_data  = '0;
		sel_top   = 1'b0;
		sel_carry = flags_reg.carry_chain_bit;
		case (REQ_IN.kind)
			DK_HALF: begin
				sel_data = {24'h000000, go_left ? h_shl : h_shr};  // RULE10
				sel_top  = sel_data[HALF_W-1];
			end
			DK_WORD, DK_PTR: begin
				if (is_rot) begin
					sel_data  = {8'h00, go_left ? w_rol : w_ror};  // RULE21
					sel_carry = go_left ? w_rol_c : w_ror_c;       // RULE22
				end else begin
					sel_data  = {8'h00, go_left ? w_shl : w_shr};  // RULE10
				end
				sel_top = sel_data[WORD_W-1];
			end
			DK_ACC0, DK_ACC1: begin
				if (is_rot) begin
					sel_data  = go_left ? a_rol : a_ror;           // RULE21
					sel_carry = go_left ? a_rol_c : a_ror_c;       // RULE22
				end else begin
					sel_data  = go_left ? a_shl : a_shr;           // RULE10
				end
				sel_top = sel_data[ACC_W-1];
			end
			default: begin
				sel_data = '0;
			end
		endcase
	end

	// only the named destination is ever written back
	always_comb begin
		res_next          = res_reg;
		if (fire) begin
			res_next.kind     = REQ_IN.kind;                 // RULE13
			res_next.dest_idx = REQ_IN.dest_idx;             // RULE13
			res_next.data     = sel_data;                    // RULE12
		end
	end

	// software write first; a hardware update in the same cycle wins
	always_comb begin
		flags_next = flags_reg;
		if (BUS_WR_IN && (BUS_ADDR_IN == ADDR_STATUS)) begin
			flags_next = lsr_flags_t'(BUS_WDATA_IN[5:0]);
		end
		if (fire) begin
			if (is_rot) begin
				flags_next.carry_chain_bit = sel_carry;      // RULE22
			end else begin
				case (REQ_IN.kind)
					DK_HALF, DK_WORD: begin
						flags_next.result_zero_flag     = (sel_data == '0);  // RULE14
						flags_next.result_negative_flag = sel_top;           // RULE14
						flags_next.data_oflow_flag      = 1'b0;              // RULE14
					end
					DK_ACC0: begin
						flags_next.result_zero_flag     = (sel_data == '0);  // RULE15
						flags_next.result_negative_flag = sel_top;           // RULE15
						flags_next.acc0_oflow_flag      = 1'b0;              // RULE15
					end
					DK_ACC1: begin
						flags_next.result_zero_flag     = (sel_data == '0);  // RULE15
						flags_next.result_negative_flag = sel_top;           // RULE15
						flags_next.acc1_oflow_flag      = 1'b0;              // RULE15
					end
					default: begin
						// pointer shifts leave every flag alone
						flags_next = flags_next;                 // RULE2
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// register read port
	// ---------------------------------------------------------------
	always_comb begin
		rdata_next = '0;
		if (BUS_RD_IN) begin
			case (BUS_ADDR_IN)
				ADDR_STATUS: rdata_next = {26'h0, flags_reg};
				ADDR_RES_LO: rdata_next = res_reg.data[WORD_W-1:0];
				ADDR_RES_HI: rdata_next = {24'h000000,
				                           res_reg.data[ACC_W-1:WORD_W]};
				default:     rdata_next = '0;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// flip-flops
	// ---------------------------------------------------------------
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			flags_reg <= lsr_flags_t'(FLAGS_RST);
		end else begin
			flags_reg <= flags_next;
		end
	end

	// fixed single-cycle latency for every form and amount
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			res_reg       <= '{kind: DK_HALF, dest_idx: '0, data: RES_RST};
			res_valid_reg <= 1'b0;
		end else begin
			res_reg       <= res_next;
			res_valid_reg <= fire;                           // RULE23
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			refused_reg <= 1'b0;
		end else begin
			refused_reg <= refuse;                           // RULE16
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign RES_OUT           = res_reg;
	assign RES_VALID_OUT     = res_valid_reg;
	assign ISSUE_REFUSED_OUT = refused_reg;
	assign FLAGS_OUT         = flags_reg;
	assign BUS_RDATA_OUT     = rdata_reg;

endmodule

`default_nettype wire

// [verif/lsr_assertions.sv]
// checker: port-level timing and flag properties of the shift/rotate unit
`timescale 1ns/100ps
`default_nettype none

module lsr_checker (
	input wire logic                SYS_CLK_IN,
	input wire logic                RST_N_IN,
	input wire lsr_pkg::lsr_req_t   REQ_IN,
	input wire logic                REQ_VALID_IN,
	input wire lsr_pkg::lsr_res_t   RES_OUT,
	input wire logic                RES_VALID_OUT,
	input wire logic                ISSUE_REFUSED_OUT,
	input wire lsr_pkg::lsr_flags_t FLAGS_OUT,
	input wire logic                BUS_WR_IN
);
	import lsr_pkg::*;
	logic go, ptr, asg, shd, rot;
	assign go = REQ_VALID_IN;
	assign ptr = go && REQ_IN.op inside {OP_PTR_R1, OP_PTR_R2, OP_PTR_L1, OP_PTR_L2};
	assign asg = go && REQ_IN.op inside {OP_ASG_RIGHT, OP_ASG_LEFT};
	assign shd = go && REQ_IN.op inside {OP_IMM_RIGHT, OP_IMM_LEFT, OP_LSHIFT};
	assign rot = go && REQ_IN.op == OP_ROT;
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	answer_once_a: assert property (go |=> RES_VALID_OUT != ISSUE_REFUSED_OUT)
		else $error("no single answer after a request");
	idle_quiet_a: assert property (!go |=> !RES_VALID_OUT && !ISSUE_REFUSED_OUT)
		else $error("answer without a request");
	short_par_a: assert property ((ptr || asg) && REQ_IN.parallel |=> ISSUE_REFUSED_OUT)
		else $error("short form issued in parallel");
	ptr_flags_a: assert property (ptr && !BUS_WR_IN |=> $stable(FLAGS_OUT))
		else $error("pointer shift moved a flag");
	ptr_left_a: assert property (ptr && REQ_IN.op == OP_PTR_L1 && REQ_IN.kind == DK_PTR
		&& !REQ_IN.parallel |=> RES_OUT.data == {8'h00, $past(REQ_IN.operand[30:0]), 1'b0})
		else $error("pointer left shift wrong");
	asg_over_a: assert property (asg && REQ_IN.kind == DK_WORD && !REQ_IN.parallel
		&& REQ_IN.amount > ASG_MAX_AMT |=> RES_VALID_OUT && RES_OUT.data == 40'h0000000000)
		else $error("oversized in-place shift not zero");
	wide_zero_a: assert property (go && REQ_IN.op == OP_LSHIFT && REQ_IN.kind == DK_HALF
		&& REQ_IN.amount[5:4] == 2'h1 |=> RES_OUT.data == 40'h0000000000 ##0 FLAGS_OUT.result_zero_flag)
		else $error("wide half-word shift not zero");
	data_ov_a: assert property (shd && REQ_IN.kind inside {DK_HALF, DK_WORD} && !BUS_WR_IN
		|=> !FLAGS_OUT.data_oflow_flag && $stable(FLAGS_OUT.carry_chain_bit))
		else $error("data shift flags wrong");
	acc_ov_a: assert property (shd && REQ_IN.kind == DK_ACC0 && !BUS_WR_IN
		|=> !FLAGS_OUT.acc0_oflow_flag && $stable(FLAGS_OUT.acc1_oflow_flag))
		else $error("accumulator shift flags wrong");
	rot_flags_a: assert property (rot && REQ_IN.kind != DK_HALF && REQ_IN.kind != DK_PTR
		&& !BUS_WR_IN |=> FLAGS_OUT[5:1] == $past(FLAGS_OUT[5:1]))
		else $error("rotate moved a status flag");
	rot_chain_a: assert property (rot && REQ_IN.kind == DK_WORD && REQ_IN.amount[5:0] == 6'h01
		|=> RES_OUT.data[0] == $past(FLAGS_OUT.carry_chain_bit)
		&& FLAGS_OUT.carry_chain_bit == $past(REQ_IN.operand[31]))
		else $error("rotate chain through carry wrong");
endmodule

bind lsr_shift_rotate_unit lsr_checker u_chk (.SYS_CLK_IN, .RST_N_IN, .REQ_IN,
	.REQ_VALID_IN, .RES_OUT, .RES_VALID_OUT, .ISSUE_REFUSED_OUT, .FLAGS_OUT, .BUS_WR_IN);

`default_nettype wire

// [verif/lsr_issuer.sv]
// partner: decoder issuing requests and register file taking write-backs
`timescale 1ns/100ps
`default_nettype none

module lsr_issuer (
	input  wire logic              clk_in,
	input  wire lsr_pkg::lsr_res_t res_in,
	input  wire logic              res_valid_in,
	output var lsr_pkg::lsr_req_t  req_out,
	output var logic               req_valid_out
);
	import lsr_pkg::*;
	logic [ACC_W-1:0] regs [16];
	initial begin
		req_out = '0;
		req_valid_out = 1'b0;
	end
	// only the destination is written, sources stay put
	always @(posedge clk_in) if (res_valid_in) regs[res_in.dest_idx] <= res_in.data;
	task automatic send(input lsr_req_t r);
		req_out <= r;
		req_valid_out <= 1'b1;
		@(posedge clk_in);
	endtask
	// idle fields toggle so stale values are never mistaken for a request
	task automatic idle();
		req_out <= lsr_req_t'(~req_out);
		req_valid_out <= 1'b0;
	endtask
endmodule

`default_nettype wire

// [verif/testbench.sv]
// testbench: directed and random shift/rotate traffic plus register bus
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import lsr_pkg::*;
	typedef struct {logic bad; logic [ACC_W-1:0] d; lsr_flags_t f;
		lsr_kind_t k; logic [3:0] i;} lsr_note_t;
	logic             clk = 1'b0;
	logic             rst_n = 1'b0;
	lsr_req_t         req;
	lsr_res_t         res;
	logic             req_valid, res_valid, refused;
	lsr_flags_t       flags, exp_f = FLAGS_RST;
	logic [7:0]       b_addr = 8'h00;
	logic [31:0]      b_wdata = 32'h0, b_rdata, lfsr = 32'h00012bac;
	logic             b_wr = 1'b0, b_rd = 1'b0;
	logic [ACC_W-1:0] last_d = RES_RST;
	logic [3:0]       last_i = 4'h0;
	logic [31:0]      asg_amt [4] = '{32'h0, 32'h1f, 32'h20, 32'hffffffff};
	lsr_note_t        notes[$];
	int               mismatches = 0, n_tests = 0;
	always #5 clk = ~clk;
	lsr_shift_rotate_unit uut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .REQ_IN(req),
		.REQ_VALID_IN(req_valid), .RES_OUT(res), .RES_VALID_OUT(res_valid),
		.ISSUE_REFUSED_OUT(refused), .FLAGS_OUT(flags), .BUS_ADDR_IN(b_addr),
		.BUS_WDATA_IN(b_wdata), .BUS_WR_IN(b_wr), .BUS_RD_IN(b_rd), .BUS_RDATA_OUT(b_rdata));
	lsr_issuer dec (.clk_in(clk), .res_in(res), .res_valid_in(res_valid),
		.req_out(req), .req_valid_out(req_valid));
	// ----
	// helpers
	// ----
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic ok, input string what);
		n_tests++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask
	function automatic void calc(input lsr_req_t r, inout lsr_flags_t f, output lsr_note_t n);
		int w, s;
		logic [ACC_W-1:0] m, v;
		logic c, t;
		w = r.kind == DK_HALF ? 16 : r.kind inside {DK_ACC0, DK_ACC1} ? 40 : 32;
		m = w == 40 ? '1 : (40'h1 << w) - 40'h1;
		v = r.operand & m;
		s = $signed(r.amount[5:0]);
		n.f = f;
		case (r.op)
		OP_PTR_R1, OP_PTR_R2, OP_PTR_L1, OP_PTR_L2: begin
			n.bad = r.kind != DK_PTR || r.parallel;
			s = r.op inside {OP_PTR_R1, OP_PTR_L1} ? 1 : 2;
			if (r.op inside {OP_PTR_R1, OP_PTR_R2}) s = -s;
		end
		OP_ASG_RIGHT, OP_ASG_LEFT: begin
			n.bad = r.kind != DK_WORD || r.parallel;
			s = r.amount > 32'h1f ? 40 : int'(r.amount[4:0]);
			if (r.op == OP_ASG_RIGHT) s = -s;
		end
		OP_IMM_RIGHT, OP_IMM_LEFT: begin
			n.bad = r.kind == DK_PTR;
			s = w == 16 ? int'(r.amount[3:0]) : int'(r.amount[4:0]);
			if (r.op == OP_IMM_RIGHT) s = -s;
		end
		default: n.bad = r.kind == DK_PTR || (r.op == OP_ROT && r.kind == DK_HALF);
		endcase
		if (r.op == OP_ROT) begin
			c = f.carry_chain_bit;
			repeat (s < 0 ? -s : s) begin
				t = s > 0 ? v[w-1] : v[0];
				v = s > 0 ? ((v << 1) | 40'(c)) & m : (v >> 1) | (40'(c) << (w - 1));
				c = t;
			end
			n.f.carry_chain_bit = c;
		end else begin
			v = (s < 0 ? v >> -s : v << s) & m;
			if (r.op > OP_PTR_L2) begin
				n.f.result_zero_flag = v == 0;
				n.f.result_negative_flag = v[w-1];
				if (r.kind == DK_ACC0) n.f.acc0_oflow_flag = 1'b0;
				else if (r.kind == DK_ACC1) n.f.acc1_oflow_flag = 1'b0;
				else n.f.data_oflow_flag = 1'b0;
			end
		end
		n.d = v;
		if (n.bad) n.f = f;
		f = n.f;
	endfunction
	task automatic issue(input lsr_op_t op, input lsr_kind_t k, input logic [ACC_W-1:0] v,
		input logic [31:0] a, input logic p);
		lsr_req_t  r;
		lsr_note_t n;
		r = '{op: op, kind: k, operand: v, amount: a, dest_idx: lfsr[3:0], parallel: p};
		calc(r, exp_f, n);
		n.k = k;
		n.i = r.dest_idx;
		if (!n.bad) begin
			last_d = n.d;
			last_i = r.dest_idx;
		end
		notes.push_back(n);
		lfsr = nxt(lfsr);
		dec.send(r);
	endtask
	task automatic quiet();
		dec.idle();
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		b_addr <= a;
		b_wdata <= d;
		b_wr <= 1'b1;
		@(posedge clk);
		b_wr <= 1'b0;
		if (a == ADDR_STATUS) exp_f = d[5:0];
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		b_addr <= a;
		b_rd <= 1'b1;
		@(posedge clk);
		b_rd <= 1'b0;
		#1 check(b_rdata === e, "bus read");
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// results are matched against the oldest note one cycle after issue
	always @(posedge clk) begin
		lsr_note_t n;
		#1;
		if (res_valid === 1'b1 || refused === 1'b1) begin
			if (notes.size() == 0) check(1'b0, "result without request");
			else begin
				n = notes.pop_front();
				check(refused === n.bad, "refusal");
				check(n.bad || res.data === n.d, "result data");
				check(n.bad || res.kind === n.k && res.dest_idx === n.i, "dest");
				check(flags === n.f, "flags");
			end
		end
	end
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		$display("[ERR] %0t timeout", $time);
		give_verdict();
	end
	// ----
	// scenarios
	// ----
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 check(flags === FLAGS_RST && res_valid === 1'b0 && b_rdata === 32'h0, "reset");
		wr(ADDR_STATUS, 32'h00000001);
		rd(ADDR_STATUS, 32'h00000001);
		rd(8'h0c, 32'h0);
		issue(OP_ROT, DK_WORD, 40'h00af00001a, 32'h1, 1'b0);
		issue(OP_ROT, DK_WORD, last_d, 32'hffffffc1, 1'b0);
		issue(OP_ROT, DK_WORD, 40'h00af00001a, 32'h3f, 1'b0);
		issue(OP_ROT, DK_WORD, last_d, 32'h3f, 1'b1);
		issue(OP_ROT, DK_ACC0, 40'h8123456789, 32'd22, 1'b0);
		issue(OP_ROT, DK_ACC1, 40'h8123456789, 32'h21, 1'b0);
		issue(OP_ROT, DK_WORD, 40'h0080000001, 32'h20, 1'b0);
		issue(OP_ROT, DK_WORD, 40'h0080000001, 32'h0, 1'b0);
		issue(OP_ROT, DK_HALF, 40'h0000001234, 32'h1, 1'b0);
		for (int i = 0; i < 4; i++) issue(lsr_op_t'(i), DK_PTR, 40'hff80000003, 32'h0, 1'b0);
		issue(OP_PTR_L1, DK_PTR, 40'h0000000001, 32'h0, 1'b1);
		issue(OP_PTR_R1, DK_WORD, 40'h0000000001, 32'h0, 1'b0);
		foreach (asg_amt[i]) begin
			issue(OP_ASG_RIGHT, DK_WORD, 40'h0080000001, asg_amt[i], 1'b0);
			issue(OP_ASG_LEFT, DK_WORD, 40'h0080000001, asg_amt[i], 1'b0);
		end
		issue(OP_ASG_LEFT, DK_WORD, 40'h1, 32'h1, 1'b1);
		quiet();
		wr(ADDR_STATUS, 32'h0000003e);
		issue(OP_IMM_LEFT, DK_ACC0, 40'hff00000001, 32'd31, 1'b0);
		issue(OP_IMM_RIGHT, DK_HALF, 40'h000000ffc0, 32'h14, 1'b0);
		issue(OP_IMM_LEFT, DK_WORD, 40'h0000000003, 32'd31, 1'b1);
		issue(OP_IMM_RIGHT, DK_ACC1, 40'h8000000000, 32'd25, 1'b0);
		issue(OP_LSHIFT, DK_HALF, 40'h000000ffff, 32'd20, 1'b0);
		issue(OP_LSHIFT, DK_WORD, 40'h00ffffffff, 32'h20, 1'b0);
		issue(OP_LSHIFT, DK_ACC0, 40'h0000000001, 32'hffc0001f, 1'b0);
		issue(OP_LSHIFT, DK_WORD, 40'h0012345678, 32'h0, 1'b0);
		for (int i = 0; i < 200; i++) begin
			lfsr = nxt(lfsr);
			issue(lsr_op_t'(lfsr[11:8] % 4'ha), lsr_kind_t'(lfsr[14:12] % 3'h5), {lfsr[7:0], nxt(lfsr)},
				lfsr[31:30] == 2'h0 ? lfsr : {26'h0, lfsr[21:16]}, lfsr[15]);
		end
		quiet();
		wr(ADDR_RES_LO, 32'hdeadbeef);
		rd(ADDR_RES_LO, last_d[31:0]);
		rd(ADDR_RES_HI, {24'h0, last_d[39:32]});
		rd(ADDR_STATUS, {26'h0, exp_f});
		check(dec.regs[last_i] === last_d, "write-back");
		check(notes.size() == 0, "results missing");
		give_verdict();
	end
endmodule

`default_nettype wire
